// file: core/accel_i2c_target_port.v
`timescale 1ns/1ps
// How it works
// - Two-wire target mode while chip select high.
// - Accept standard and fast bus speeds.
// - Handle single and multi-byte transfers.
// - Strap high answers address 0x1d.
// - Strap low answers address 0x53.
`include "i2c_target_regs.vh"
module accel_i2c_target_port #(
  parameter PTR_W = 8,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire srst_i,
  // Pins
  input wire cs_n_i,
  input wire bus_address_strap_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o,
  // Internal register file side
  output reg [PTR_W-1:0] reg_addr_o,
  output reg [DATA_W-1:0] reg_wdata_o,
  output reg reg_wr_o,
  output reg reg_rd_o,
  input wire [DATA_W-1:0] reg_rdata_i,
  output reg busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Engine states: idle, address byte, target ack, receive, transmit and
  // the controller's ack slot after each transmitted byte
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_TXACK = 3'd5;

  // Engine state and the sampled pin history used for edge detection
  reg [2:0] state_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  // Direction, pointer phase and the open-drain pull request
  reg rw_r;
  reg got_ptr_r;
  reg drive_low_r;
  reg ack_pend_r;
  reg [2:0] ack_next_r;

  // Deselect forces the engine idle, so traffic meant for other parts of a
  // shared bus cannot be taken for a start condition
  wire i2c_mode = cs_n_i;
  wire scl_rise = scl_i & ~scl_d_r;
  wire scl_fall = ~scl_i & scl_d_r;
  // Edge detection on sampled pins works to 400 kHz with 25 cycles per period
  wire start_cond = scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire stop_cond = scl_i & scl_d_r & ~sda_d_r & sda_i;
  // Start and stop are only legal with SCL held high across two samples;
  // the controller must keep each SCL phase at least two clocks long

  ////////////////////////////////////////////////////////////////////////////
  // Address compare against the strap-selected target address
  function addr_hit;
    input [6:0] got;
    input strap;
    begin
      addr_hit = (got == (strap ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW));
    end
  endfunction

  // Pointer step, shared by the write and read paths; wraps at the top
  function [PTR_W-1:0] ptr_step;
    input [PTR_W-1:0] ptr;
    begin
      ptr_step = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Open drain: only ever pull low. The data output is tied low and the
  // enable alone decides the line, so the device can never drive it high
  // against another pull on the bus
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_low_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin history
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always @(posedge clk_sys_i) begin
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    // Deselect acts exactly as reset; the pointer returns to its reset value
    if (srst_i || !i2c_mode) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      got_ptr_r <= 1'b0;
      drive_low_r <= 1'b0;
      ack_pend_r <= 1'b0;
      ack_next_r <= ST_IDLE;
      reg_addr_o <= `PTR_RESET;
      reg_wdata_o <= {DATA_W{1'b0}};
      busy_o <= 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the pointer for a read after a pointer write
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'd0;
      drive_low_r <= 1'b0;
      got_ptr_r <= 1'b0;
      busy_o <= 1'b1;
    end else if (stop_cond) begin
      // Stop ends any transfer; the pointer is kept for the next one
      state_r <= ST_IDLE;
      drive_low_r <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      case (state_r)
        // Wait for a start; nothing on the bus is driven
        ST_IDLE: begin
          drive_low_r <= 1'b0;
        end
        // Shift in on SCL rise; decide the ack on the fall after bit eight.
        // The first byte after the address is the pointer, the rest are data
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_i};
            bit_cnt_r <= bit_cnt_r + 3'd1;
            ack_pend_r <= (bit_cnt_r == 3'd7);
          end else if (scl_fall && ack_pend_r) begin
            ack_pend_r <= 1'b0;
            if (state_r == ST_ADDR) begin
              if (addr_hit(shift_r[7:1], bus_address_strap_i)) begin
                rw_r <= shift_r[0];
                drive_low_r <= 1'b1;
                state_r <= ST_ACK;
                ack_next_r <= shift_r[0] ? ST_TX : ST_RX;
              end else begin
                state_r <= ST_IDLE;
              end
            end else begin
              drive_low_r <= 1'b1;
              state_r <= ST_ACK;
              ack_next_r <= ST_RX;
              if (!got_ptr_r) begin
                reg_addr_o <= shift_r[PTR_W-1:0];
                got_ptr_r <= 1'b1;
              end else begin
                reg_wdata_o <= shift_r[DATA_W-1:0];
                reg_wr_o <= 1'b1;
              end
            end
          end
        end
        // Hold the ack low for the whole ninth clock, release on its fall
        // and load the first read bit there when the transfer is a read
        ST_ACK: begin
          if (scl_fall) begin
            drive_low_r <= 1'b0;
            bit_cnt_r <= 3'd0;
            state_r <= ack_next_r;
            if (ack_next_r == ST_TX) begin
              shift_r <= reg_rdata_i;
              reg_rd_o <= 1'b1;
              drive_low_r <= ~reg_rdata_i[7];
            end
          end
          // Advance after a written data byte once its strobe has issued;
          // the register file has taken the byte at the old pointer by then
          if (reg_wr_o) begin
            reg_addr_o <= ptr_step(reg_addr_o);
          end
        end
        // Present each bit one clock after SCL falls; the pointer moves on
        // as soon as the last bit is out, ready for a following byte
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 3'd7) begin
              drive_low_r <= 1'b0;
              state_r <= ST_TXACK;
              reg_addr_o <= ptr_step(reg_addr_o);
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              drive_low_r <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + 3'd1;
            end
          end
        end
        ST_TXACK: begin
          // Controller ack means another byte; nack ends the read
          if (scl_rise) begin
            state_r <= sda_i ? ST_IDLE : ST_ACK;
            ack_next_r <= ST_TX;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: core/i2c_target_regs.vh
`ifndef I2C_TARGET_REGS_VH
`define I2C_TARGET_REGS_VH
// Target addresses selected by the address strap
`define ADDR_STRAP_HIGH 7'h1d
`define ADDR_STRAP_LOW 7'h53
// Bus speeds supported, in kHz
`define SPEED_STD_KHZ 100
`define SPEED_FAST_KHZ 400
// System clock rate, in kHz
`define CLK_SYS_KHZ 10000
// Least system cycles per SCL period at fast mode (rounded down)
`define SCL_FAST_CYCLES (`CLK_SYS_KHZ / `SPEED_FAST_KHZ)
// Reset value of the register pointer
`define PTR_RESET 8'h00
`endif

// file: verification/port_sva.sv
`timescale 1ns/1ps
// Port checks for the bus target
module port_sva (
  // Clock and reset
  input wire clk_sys_i,
  input wire srst_i,
  // Watched ports
  input wire cs_n_i,
  input wire scl_i,
  input wire sda_oe_n_o,
  input wire reg_wr_o,
  input wire [7:0] reg_addr_o,
  input wire busy_o,
  input wire sda_o,
  input wire reg_rd_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Select low parks the engine, so foreign traffic is ignored
  chk_sel_idle: assert property (!cs_n_i |=> sda_oe_n_o && !busy_o)
    else $error("active while deselected");
  chk_drive_hold: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
    else $error("data moved with clock high");
  chk_ptr_step: assert property (reg_wr_o |=> reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("pointer did not step");
  chk_wr_busy: assert property (reg_wr_o |-> busy_o ##1 !reg_wr_o)
    else $error("bad write strobe");
  chk_rd_pulse: assert property (reg_rd_o |-> busy_o ##1 !reg_rd_o)
    else $error("bad read strobe");
  chk_reset_idle: assert property ($past(srst_i) |-> sda_oe_n_o && !busy_o && reg_addr_o == 8'h00)
    else $error("not idle after reset");
  chk_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
endmodule
bind accel_i2c_target_port port_sva u_sva (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .cs_n_i(cs_n_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o), .reg_wr_o(reg_wr_o),
  .reg_addr_o(reg_addr_o), .busy_o(busy_o), .sda_o(sda_o), .reg_rd_o(reg_rd_o));

// file: verification/host.sv
`timescale 1ns/1ps
// Bus controller; data is open drain with a pull-up
module host (
  input wire clk_sys_i,
  input wire sda_oe_n_o,
  output reg scl_o = 1'b1,
  output reg sdd_o = 1'b1,
  output wire sda_o
);
  integer n = 13;
  // Wired AND: a released line floats high
  assign sda_o = sdd_o & sda_oe_n_o;
  // One phase lasts n clocks: 13 keeps fast mode under 400 kHz, 50 is standard
  task ph(input s, input d);
    @(posedge clk_sys_i);
    scl_o <= s;
    sdd_o <= d;
    repeat (n - 1) @(posedge clk_sys_i);
  endtask
  // Start when s is 0, stop when s is 1
  task cond(input s);
    ph(1'b0, ~s);
    ph(1'b1, ~s);
    ph(1'b1, s);
  endtask
  // Nine bits; the line is sampled late in the high phase
  task x(input [8:0] b, output [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
      r[i] = sda_o;
    end
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  reg clk_sys_i, srst_i, cs_n_i, strap;
  wire scl, sdd, sda, oe_n, wr, busy;
  wire [7:0] addr, wdata;
  reg [7:0] rf [0:255];
  reg [7:0] q [$];
  reg [7:0] a8, d;
  reg [8:0] r;
  integer miscompares, total_checks, k, p;
  accel_i2c_target_port u_accel_i2c_target_port (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .cs_n_i(cs_n_i), .bus_address_strap_i(strap), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_n_o(oe_n), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(), .reg_rdata_i(rf[addr]), .busy_o(busy));
  host u_host (.clk_sys_i(clk_sys_i), .sda_oe_n_o(oe_n), .scl_o(scl), .sdd_o(sdd), .sda_o(sda));
  // Register file behind the port
  always @(posedge clk_sys_i) if (wr) rf[addr] <= wdata;
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task chk(input [8*4:1] n, input [7:0] e, input [7:0] g);
    total_checks++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %0s exp %h got %h", n, e, g);
    end
  endtask
  // Byte out with the ninth bit released for the target's reply
  task w(input [7:0] b);
    u_host.x({b, 1'b1}, r);
  endtask
  task wrap_up;
    $display("checks %0d bad %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Passes: fast strap high, standard strap low, foreign address, select low
  // Register traffic only; no data rate is raised, so the rate limit holds
  initial begin
    srst_i = 1'b1;
    cs_n_i = 1'b1;
    strap = 1'b1;
    miscompares = 0;
    total_checks = 0;
    k = $urandom(71707);
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (k = 0; k < 4; k++) begin
      strap <= ~k[0];
      cs_n_i <= k != 3;
      u_host.n = k ? 50 : 13;
      a8 = (k[0] ^ (k == 2)) ? 8'ha6 : 8'h3a;
      p = $urandom % 255;
      u_host.cond(1'b0);
      w(a8);
      chk("ack", {7'h0, k > 1}, {7'h0, r[0]});
      if (k < 2) begin
        w(p[7:0]);
        repeat (2) begin
          d = $urandom;
          q.push_back(d);
          w(d);
        end
        u_host.cond(1'b0);
        w(a8);
        w(p[7:0]);
        u_host.cond(1'b0);
        w(a8 | 8'h01);
        u_host.x({8'hff, 1'b0}, r);
        chk("rd0", q.pop_front(), r[8:1]);
        u_host.x({8'hff, 1'b1}, r);
        chk("rd1", q.pop_front(), r[8:1]);
      end
      u_host.cond(1'b1);
      chk("busy", 8'h00, {7'h0, busy});
      $display("pass %0d done", k);
    end
    wrap_up;
  end
endmodule
